// ---- smsp_top.sv ----
// Serial master/slave port with APB register access
//
// Added by the designer: the APB slave port.
module smsp_top
  import smsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire smsp_pkg::smsp_pins_in_t i_pins,
  input wire smsp_pkg::smsp_dir_t i_dir,
  input wire logic i_global_irq_en,
  input wire logic i_vector_taken,
  output smsp_pkg::smsp_pins_out_t o_pins,
  output logic o_irq
);
  import smsp_pkg::*;

  // --------------------------------------------------------------------
  // Registers and bus decode
  // --------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic done_q, write_collision_flag_q, dbl_q;
  logic [7:0] shift_q, rxbuf_q;
  logic [2:0] bitcnt_q;
  logic [6:0] divcnt_q;
  logic sclk_q, armed_q, sin_q;
  // Byte finish lags the last edge by a cycle so the far side settles
  logic fin_q, in_bit, drop;
  logic [1:0] sclk_hist_q;
  smsp_state_t state_q;

  logic acc, wr, rd, hit_ctl, hit_st, hit_dat;
  assign acc = i_ce && i_psel && i_penable && o_pready;
  assign wr = acc && i_pwrite && i_pstrb[0];
  assign rd = acc && !i_pwrite;
  assign hit_ctl = i_paddr == SMSP_ADDR_CONTROL;
  assign hit_st = i_paddr == SMSP_ADDR_STATUS;
  assign hit_dat = i_paddr == SMSP_ADDR_DATA;

  logic en, master, clock_polarity, clock_phase, lsb_first, busy;
  assign en = ctrl_q[SMSP_B_PORT_EN];
  assign master = ctrl_q[SMSP_B_ROLE];
  assign clock_polarity = ctrl_q[SMSP_B_CLOCK_POLARITY];
  assign clock_phase = ctrl_q[SMSP_B_CLOCK_PHASE];
  assign lsb_first = ctrl_q[SMSP_B_ORDER];
  assign busy = state_q != SMSP_IDLE || fin_q;

  // Half period select, used by master role only
  function automatic logic [6:0] half_of(input logic [2:0] code);
    unique case (code)
      3'b000: half_of = SMSP_HALF_4;
      3'b001: half_of = SMSP_HALF_16;
      3'b010: half_of = SMSP_HALF_64;
      3'b011: half_of = SMSP_HALF_128;
      3'b100: half_of = SMSP_HALF_2;
      3'b101: half_of = SMSP_HALF_8;
      3'b110: half_of = SMSP_HALF_32;
      3'b111: half_of = SMSP_HALF_64;
    endcase
  endfunction

  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic lsb, input logic b);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Select loss: master with select as input seeing low
  logic sel_loss;
  assign sel_loss = en && master && !i_dir.sel_dir_out && !i_pins.sel_in;

  // Slave engine enabled only while select is low
  logic slave_act;
  assign slave_act = en && !master && !i_pins.sel_in;
  assign drop = !en || sel_loss || (!master && i_pins.sel_in);
  // Master reads the far slave's line live at its own shift edge
  assign in_bit = master ? i_pins.miso_in : sin_q;

  // --------------------------------------------------------------------
  // Slave clock edge detection; pins are synchronous to i_clk
  // --------------------------------------------------------------------
  logic s_lead, s_trail;
  assign s_lead = slave_act && (sclk_hist_q[0] != sclk_hist_q[1])
                  && (sclk_hist_q[0] != clock_polarity);
  assign s_trail = slave_act && (sclk_hist_q[0] != sclk_hist_q[1])
                   && (sclk_hist_q[0] == clock_polarity);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_hist_q <= 2'b00;
    end else if (i_ce) begin
      sclk_hist_q <= {sclk_hist_q[0], i_pins.sclk_in};
    end
  end

  // Master divider tick
  logic m_tick;
  assign m_tick = busy && master && (divcnt_q == SMSP_ONE7);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      divcnt_q <= SMSP_ONE7;
    end else if (i_ce) begin
      if (!busy || m_tick) begin
        divcnt_q <= half_of({dbl_q, ctrl_q[1:0]});
      end else begin
        divcnt_q <= divcnt_q - SMSP_ONE7;
      end
    end
  end

  // --------------------------------------------------------------------
  // Shift engine: sample on one edge, drive on the other
  // --------------------------------------------------------------------
  logic lead_ev, trail_ev, start_m, start_w, samp_ev, setup_ev, last_samp;
  assign start_w = wr && hit_dat;
  assign start_m = start_w && en && master && !busy && !sel_loss;
  assign lead_ev = (master && state_q == SMSP_LEAD && m_tick) || s_lead;
  assign trail_ev = (master && state_q == SMSP_TRAIL && m_tick) || s_trail;
  assign samp_ev = clock_phase ? trail_ev : lead_ev;
  assign setup_ev = clock_phase ? lead_ev : trail_ev;
  assign last_samp = samp_ev && bitcnt_q == SMSP_BITCNT_LAST;

  logic byte_end;
  // Byte ends at the last trailing edge
  assign byte_end = clock_phase ? last_samp : (trail_ev && armed_q);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fin_q <= 1'b0;
    end else if (i_ce) begin
      fin_q <= byte_end && !drop;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= SMSP_IDLE;
      bitcnt_q <= 3'h0;
      shift_q <= SMSP_DATA_RST;
      sin_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (i_ce) begin
      if (drop) begin
        // Drop any partial byte immediately
        state_q <= SMSP_IDLE;
        bitcnt_q <= 3'h0;
        armed_q <= 1'b0;
        if (start_w && !busy) begin
          shift_q <= i_pwdata[7:0];
        end
      end else if (start_m || (start_w && !master && !busy)) begin
        shift_q <= i_pwdata[7:0];
        state_q <= master ? SMSP_LEAD : SMSP_IDLE;
      end else begin
        if (s_lead || s_trail) begin
          state_q <= s_lead ? SMSP_TRAIL : SMSP_LEAD;
        end else if (lead_ev) begin
          state_q <= SMSP_TRAIL;
        end else if (trail_ev) begin
          state_q <= byte_end ? SMSP_IDLE : SMSP_LEAD;
        end
        if (samp_ev) begin
          sin_q <= master ? i_pins.miso_in : i_pins.mosi_in;
          bitcnt_q <= bitcnt_q + 3'h1;
          if (last_samp) begin
            armed_q <= 1'b1;
          end
        end
        if (setup_ev && !(clock_phase && bitcnt_q == 3'h0)) begin
          // First leading edge of phase one already shows the first bit
          shift_q <= shift_in(shift_q, lsb_first, in_bit);
        end
        if (byte_end) begin
          armed_q <= 1'b0;
          if (!master) begin
            state_q <= SMSP_IDLE;
          end
        end
      end
    end
  end

  // Receive buffer: overwritten when a new byte ends
  logic [7:0] rx_final;
  assign rx_final = clock_phase ? shift_in(shift_q, lsb_first, in_bit) : shift_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxbuf_q <= SMSP_DATA_RST;
    end else if (i_ce && fin_q) begin
      rxbuf_q <= rx_final;
    end
  end

  // --------------------------------------------------------------------
  // Control register; role bit cleared by a select loss
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= SMSP_CTRL_RST;
    end else if (i_ce) begin
      if (wr && hit_ctl) begin
        ctrl_q <= i_pwdata[7:0];
      end
      if (sel_loss) begin
        ctrl_q[SMSP_B_ROLE] <= 1'b0;
      end
    end
  end

  // Status flags: set wins over the clear sequence
  logic st_seen_q, clr_seq;
  assign clr_seq = acc && hit_dat && st_seen_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_seen_q <= 1'b0;
    end else if (i_ce && acc) begin
      st_seen_q <= rd && hit_st && (done_q || write_collision_flag_q);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      dbl_q <= 1'b0;
    end else if (i_ce) begin
      if (fin_q || sel_loss) begin
        done_q <= 1'b1;
      end else if (clr_seq || i_vector_taken) begin
        done_q <= 1'b0;
      end
      if (start_w && busy) begin
        write_collision_flag_q <= 1'b1;
      end else if (clr_seq) begin
        write_collision_flag_q <= 1'b0;
      end
      if (wr && hit_st) begin
        dbl_q <= i_pwdata[SMSP_B_DBL];
      end
    end
  end

  // --------------------------------------------------------------------
  // APB answer: single wait-free cycle, error on unmapped address
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !(hit_ctl || hit_st || hit_dat);
      o_prdata <= 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
        if (hit_ctl) begin
          o_prdata[7:0] <= ctrl_q;
        end else if (hit_st) begin
          o_prdata[7:0] <= {done_q, write_collision_flag_q, 5'h00, dbl_q};
        end else if (hit_dat) begin
          o_prdata[7:0] <= rxbuf_q;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Pins and interrupt
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q <= 1'b0;
      o_pins <= '{sclk_out: 1'b0, sclk_oe_n: 1'b1, mosi_out: 1'b0,
                  mosi_oe_n: 1'b1, miso_out: 1'b0, miso_oe_n: 1'b1,
                  sel_out: 1'b1, sel_oe_n: 1'b1};
      o_irq <= 1'b0;
    end else if (i_ce) begin
      sclk_q <= (master && state_q == SMSP_TRAIL) ? !clock_polarity : clock_polarity;
      o_pins.sclk_out <= (master && state_q == SMSP_TRAIL) ? !clock_polarity : clock_polarity;
      o_pins.mosi_out <= out_bit(shift_q, lsb_first);
      o_pins.miso_out <= out_bit(shift_q, lsb_first);
      o_pins.sclk_oe_n <= !(en && master && i_dir.sclk_dir_out);
      o_pins.mosi_oe_n <= !(en && master && i_dir.mosi_dir_out);
      o_pins.miso_oe_n <= !(slave_act && i_dir.miso_dir_out);
      o_pins.sel_out <= i_dir.sel_gpio_val;
      o_pins.sel_oe_n <= !(i_dir.sel_dir_out && (master || !en));
      o_irq <= ctrl_q[SMSP_B_IRQ_EN] && done_q && i_global_irq_en;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  role_loss_a: assert property (i_ce && sel_loss |=> !master && done_q)
    else $error("select loss did not clear role or set done");
  sel_reset_a: assert property (i_ce && !master && i_pins.sel_in
    |=> state_q == SMSP_IDLE && bitcnt_q == 3'h0)
    else $error("slave not reset by select high");
  disabled_a: assert property (i_ce && !en |=> !busy)
    else $error("engine active while disabled");
  irq_gate_a: assert property (i_ce && $past(i_ce) && o_irq
    |-> $past(done_q && i_global_irq_en))
    else $error("interrupt without cause");
  write_collision_flag_set_a: assert property (i_ce && start_w && busy |=> write_collision_flag_q)
    else $error("collision not flagged");
  status_res_a: assert property (o_pready && i_penable && hit_st
    && !i_pwrite |-> o_prdata[5:1] == 5'h00)
    else $error("reserved status bits not zero");
  done_set_a: assert property (i_ce && fin_q |=> done_q)
    else $error("done not set at byte end");
  miso_drive_a: assert property (!o_pins.miso_oe_n |-> $past(!master))
    else $error("master-in driven in master role");
  sclk_idle_a: assert property (i_ce && !busy |=> sclk_q == $past(clock_polarity))
    else $error("serial clock idle level wrong");

  master_byte_c: cover property (i_ce && master && byte_end);
  slave_byte_c: cover property (i_ce && !master && byte_end);
  loss_c: cover property (sel_loss);
endmodule

// ---- smsp_pkg.sv ----
// Package for the serial master/slave port: offsets, fields, types
package smsp_pkg;
  // ----------------------------------------------------------------------
  // Register word indices (0x2d, 0x2e printed; control chosen); byte address is index times 4
  // ----------------------------------------------------------------------
  localparam logic [11:0] SMSP_IDX_STATUS = 12'h02d;
  localparam logic [11:0] SMSP_IDX_DATA = 12'h02e;
  localparam logic [11:0] SMSP_IDX_CONTROL = 12'h02c;
  localparam logic [11:0] SMSP_ADDR_STATUS = {SMSP_IDX_STATUS[9:0], 2'b00};
  localparam logic [11:0] SMSP_ADDR_DATA = {SMSP_IDX_DATA[9:0], 2'b00};
  localparam logic [11:0] SMSP_ADDR_CONTROL = {SMSP_IDX_CONTROL[9:0], 2'b00};
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SMSP_B_IRQ_EN = 7;
  localparam int SMSP_B_PORT_EN = 6;
  localparam int SMSP_B_ORDER = 5;
  localparam int SMSP_B_ROLE = 4;
  localparam int SMSP_B_CLOCK_POLARITY = 3;
  localparam int SMSP_B_CLOCK_PHASE = 2;
  localparam int SMSP_B_DONE = 7;
  localparam int SMSP_B_WRITE_COLLISION_FLAG = 6;
  localparam int SMSP_B_DBL = 0;
  localparam logic [7:0] SMSP_CTRL_RST = 8'h00;
  localparam logic [7:0] SMSP_STAT_RST = 8'h00;
  localparam logic [7:0] SMSP_DATA_RST = 8'h00;
  localparam logic [3:0] SMSP_BITS = 4'h8;
  localparam logic [2:0] SMSP_BITCNT_LAST = 3'h7;
  localparam logic [6:0] SMSP_ONE7 = 7'h01;
  // Half periods of the serial clock in system cycles, indexed by rate code
  localparam logic [6:0] SMSP_HALF_4 = 7'h02;
  localparam logic [6:0] SMSP_HALF_16 = 7'h08;
  localparam logic [6:0] SMSP_HALF_64 = 7'h20;
  localparam logic [6:0] SMSP_HALF_128 = 7'h40;
  localparam logic [6:0] SMSP_HALF_2 = 7'h01;
  localparam logic [6:0] SMSP_HALF_8 = 7'h04;
  localparam logic [6:0] SMSP_HALF_32 = 7'h10;

  typedef enum logic [2:0] {
    SMSP_IDLE = 3'b001,
    SMSP_LEAD = 3'b010,
    SMSP_TRAIL = 3'b100
  } smsp_state_t;

  // Serial pins toward the far party; oe_n low means the pin is driven
  typedef struct packed {
    logic sclk_out;
    logic sclk_oe_n;
    logic mosi_out;
    logic mosi_oe_n;
    logic miso_out;
    logic miso_oe_n;
    logic sel_out;
    logic sel_oe_n;
  } smsp_pins_out_t;

  typedef struct packed {
    logic sclk_in;
    logic mosi_in;
    logic miso_in;
    logic sel_in;
  } smsp_pins_in_t;

  // User port direction choices, as set by software elsewhere
  typedef struct packed {
    logic sclk_dir_out;
    logic mosi_dir_out;
    logic miso_dir_out;
    logic sel_dir_out;
    logic sel_gpio_val;
  } smsp_dir_t;
endpackage

// ---- smsp_remote.sv ----
// Remote serial party model: slave to the port, or master driving it
module smsp_remote (
  input wire logic i_clk,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  input wire logic i_clock_polarity,
  input wire logic i_clock_phase,
  input wire logic i_lsb,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_sel_n,
  output logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  int s = 0;
  int idx;
  logic tgl = 1'b0;
  logic drv = 1'b0;
  logic mbit = 1'b0;
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_rx = 8'h00;
  end
  function automatic logic pick(input logic [7:0] b, input int k);
    return i_lsb ? b[k] : b[7-k];
  endfunction
  // Released lines toggle so a stale level never passes for data
  always @(posedge i_clk) tgl <= ~tgl;
  always_comb begin
    idx = i_clock_phase ? s - 1 : s;
    o_miso = (i_sel_n || idx < 0 || idx > 7) ? tgl : pick(i_tx, idx);
    o_mosi = drv ? mbit : tgl;
  end
  always @(negedge i_sel_n) s = 0;
  // Sample on one edge, shift on the other
  always @(i_sclk) begin
    if (!i_sel_n) begin
      if (i_sclk == !(i_clock_polarity ^ i_clock_phase))
        o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      else
        s = s + 1;
    end
  end
  // Acting as master: 4-cycle phases keep the rate at an eighth of the system clock
  task automatic run_master(input logic [7:0] b, input int n);
    @(posedge i_clk);
    o_sclk <= i_clock_polarity;
    o_sel_n <= 1'b0;
    drv <= 1'b1;
    for (int k = 0; k < n; k++) begin
      if (!i_clock_phase) mbit <= pick(b, k);
      repeat (4) @(posedge i_clk);
      o_sclk <= ~o_sclk;
      if (i_clock_phase) mbit <= pick(b, k);
      repeat (4) @(posedge i_clk);
      o_sclk <= ~o_sclk;
    end
    repeat (4) @(posedge i_clk);
    o_sel_n <= 1'b1;
    drv <= 1'b0;
  endtask
endmodule

// ---- smsp_top_test.sv ----
// Self-checking bench for the serial master/slave port
module smsp_top_test;
  import smsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CTL = SMSP_ADDR_CONTROL;
  localparam logic [11:0] A_STA = SMSP_ADDR_STATUS;
  localparam logic [11:0] A_DAT = SMSP_ADDR_DATA;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic gie = 1'b1;
  logic vec = 1'b0;
  logic tb_sel_n = 1'b1;
  logic clock_polarity = 1'b0;
  logic clock_phase = 1'b0;
  logic lsb = 1'b0;
  logic [7:0] rtx = 8'h00;
  logic [7:0] r_rx;
  smsp_dir_t dir = 5'b11010;
  smsp_pins_in_t pin_i;
  smsp_pins_out_t pin_o;
  wire logic r_miso, r_sclk, r_mosi, r_sel_n;
  wire logic sck_w = !pin_o.sclk_oe_n ? pin_o.sclk_out : r_sclk;
  wire logic mosi_w = !pin_o.mosi_oe_n ? pin_o.mosi_out : r_mosi;
  wire logic miso_w = !pin_o.miso_oe_n ? pin_o.miso_out : r_miso;
  wire logic sel_w = !pin_o.sel_oe_n ? pin_o.sel_out : (r_sel_n & tb_sel_n);
  assign pin_i = {sck_w, mosi_w, miso_w, sel_w};
  int mismatches = 0;
  int checks = 0;
  int edges = 0;
  logic [31:0] expq[$];
  logic [6:0] half_of[8] = '{SMSP_HALF_4, SMSP_HALF_16, SMSP_HALF_64,
    SMSP_HALF_128, SMSP_HALF_2, SMSP_HALF_8, SMSP_HALF_32, SMSP_HALF_64};
  initial forever #5 clk = ~clk;
  always @(pin_o.sclk_out) edges++;
  smsp_top dut_u (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pins(pin_i), .i_dir(dir),
    .i_global_irq_en(gie), .i_vector_taken(vec), .o_pins(pin_o), .o_irq(irq));
  smsp_remote rem_u (.i_clk(clk), .i_sclk(sck_w), .i_mosi(mosi_w),
    .i_sel_n(sel_w), .i_clock_polarity(clock_polarity), .i_clock_phase(clock_phase), .i_lsb(lsb), .i_tx(rtx),
    .o_miso(r_miso), .o_sclk(r_sclk), .o_mosi(r_mosi), .o_sel_n(r_sel_n),
    .o_rx(r_rx));
  // --------------------------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Read answers are compared by the watcher below, oldest note first
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) chk("rdata_extra", 32'h1, 32'h0);
      else chk("rdata", prdata, expq.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic err);
    int n;
    n = 0;
    if (!w) expq.push_back({24'h0, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h0, 32'h1);
      end_of_test();
    end
    chk("pslverr", pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq(input int bound, output int n);
    n = 0;
    while (irq !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) begin
      chk("irq_wait", 32'h0, 32'h1);
      end_of_test();
    end
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    logic [2:0] code;
    logic [7:0] ctl, tx;
    int n, e0, h;
    void'($urandom(83));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    apb(0, A_STA, SMSP_STAT_RST, 0);
    apb(0, A_CTL, SMSP_CTRL_RST, 0);
    apb(0, 12'h0fc, 8'h00, 1);
    // All four modes, random order, rate and double speed
    for (int m = 0; m < 4; m++) begin
      code = 3'($urandom_range(7));
      lsb <= 1'($urandom_range(1));
      rtx <= 8'($urandom);
      tx = 8'($urandom);
      clock_polarity <= m[1];
      clock_phase <= m[0];
      h = int'(half_of[code]);
      dir <= 5'b11011;
      @(posedge clk);
      ctl = {2'b11, lsb, 1'b1, 2'(m), code[1:0]};
      apb(1, A_STA, {7'h7f, code[2]}, 0);
      apb(1, A_CTL, ctl, 0);
      apb(0, A_STA, {7'h00, code[2]}, 0);
      dir <= 5'b11010;
      e0 = edges;
      apb(1, A_DAT, tx, 0);
      wait_irq(3000, n);
      chk("sclk_edges", edges - e0, 16);
      chk("byte_time", n >= 16 * h - 2 && n <= 16 * h + 8, 1);
      chk("sclk_idle", pin_o.sclk_out, clock_polarity);
      chk("far_rx", r_rx, tx);
      apb(0, A_CTL, ctl, 0);
      apb(0, A_STA, {7'h40, code[2]}, 0);
      apb(0, A_DAT, rtx, 0);
      apb(0, A_STA, {7'h00, code[2]}, 0);
      chk("irq_low", irq, 0);
    end
    // Second write mid-byte collides and is dropped; vector clears done
    clock_polarity <= 1'b0;
    clock_phase <= 1'b0;
    lsb <= 1'b0;
    tx = 8'($urandom);
    dir <= 5'b11011;
    apb(1, A_CTL, 8'hd0, 0);
    apb(1, A_STA, 8'h00, 0);
    dir <= 5'b11010;
    apb(1, A_DAT, tx, 0);
    apb(1, A_DAT, ~tx, 0);
    wait_irq(200, n);
    chk("far_rx_write_collision_flag", r_rx, tx);
    vec <= 1'b1;
    @(posedge clk);
    vec <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq_vector", irq, 0);
    apb(0, A_STA, 8'h40, 0);
    apb(0, A_DAT, rtx, 0);
    apb(0, A_STA, 8'h00, 0);
    // Port disabled: no clock, pins released
    apb(1, A_CTL, 8'h90, 0);
    e0 = edges;
    apb(1, A_DAT, 8'h3c, 0);
    repeat (60) @(posedge clk);
    chk("off_edges", edges - e0, 0);
    chk("off_pins", {pin_o.sclk_oe_n, pin_o.mosi_oe_n, irq}, 3'b110);
    // Select input pulled low by another master
    dir <= 5'b11000;
    apb(1, A_CTL, 8'hd0, 0);
    tb_sel_n <= 1'b0;
    wait_irq(20, n);
    repeat (2) @(posedge clk);
    chk("lost_pins", {pin_o.sclk_oe_n, pin_o.mosi_oe_n}, 2'b11);
    tb_sel_n <= 1'b1;
    apb(0, A_CTL, 8'hc0, 0);
    apb(0, A_STA, 8'h80, 0);
    apb(0, A_DAT, rtx, 0);
    // Slave role: aborted partial byte, then a whole one
    dir <= 5'b00101;
    apb(1, A_CTL, 8'hc3, 0);
    tx = 8'($urandom);
    rem_u.run_master(~tx, 4);
    repeat (4) @(posedge clk);
    apb(0, A_STA, 8'h00, 0);
    rem_u.run_master(tx, 8);
    wait_irq(40, n);
    apb(0, A_STA, 8'h80, 0);
    apb(0, A_DAT, tx, 0);
    chk("slave_miso", {pin_o.miso_oe_n, pin_o.sel_oe_n}, 2'b11);
    repeat (3) @(posedge clk);
    chk("queue_empty", expq.size(), 0);
    end_of_test();
  end
endmodule
